// ---- src/cog_dev.sv ----
/*
  Device end: serial receiver, register bank and the clock output paths
  it steers (group dividers, output buffer enables, oscillator buffers).
  Assumes hclk doubles as the reference; the reference input is hclk/2.
*/
// Design decision made here: register access over the three-wire serial link.
`timescale 1ns/1ns
module cog_dev (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // serial link
  cog_link_if.dev          link,
  // clock outputs
  output logic [5:0]       group_clk,
  output logic [5:0]       group_extended,
  output logic [11:0]      output_on,
  output logic [47:0]      output_format,
  output logic             osc_buffer_first,
  output logic             osc_buffer_second,
  output logic             osc_buf0_on,
  output logic             osc_buf1_on,
  output logic [1:0]       osc_buf1_amplitude,
  // status
  output logic             device_powerdown,
  output logic             reset_flag,
  output logic             register_write_lock,
  output logic             output_six_ready,
  output logic             sync_pulse
);
  logic [31:0] regs [0:11];
  logic [2:0]  sclk_sync;
  logic [2:0]  data_sync;
  logic [2:0]  le_sync;
  logic        sclk_flt;
  logic        data_flt;
  logic        le_flt;
  logic        sclk_prev;
  logic        le_prev;
  logic [31:0] shift;
  logic [10:0] grp_cnt [0:5];
  logic [2:0]  osc_cnt;
  logic        osc_div_clk;
  logic        ref_clk;

  function automatic logic [3:0] reg_index(input logic [4:0] addr);
    if (addr == cog_pkg::ADDR_LOCK) begin
      reg_index = 4'hB;
    end else if (addr == cog_pkg::ADDR_SYNC_CTL) begin
      reg_index = 4'hF;
    end else if (addr <= cog_pkg::ADDR_OSC) begin
      reg_index = addr[3:0];
    end else begin
      reg_index = 4'hF;
    end
  endfunction : reg_index

  function automatic logic [2:0] osc_divisor(input logic [2:0] code);
    if (code == cog_pkg::OSC_DIV_MAX) begin
      osc_divisor = 3'h0; // zero here means eight: counter wraps at 7
    end else if (code == cog_pkg::OSC_DIV_TWO) begin
      osc_divisor = 3'h2;
    end else begin
      osc_divisor = code;
    end
  endfunction : osc_divisor

  function automatic logic [31:0] default_word(input int unsigned idx);
    if (idx <= 5) begin
      default_word = cog_pkg::DEF_GROUP;
    end else if (idx <= 8) begin
      default_word = cog_pkg::DEF_FMT;
    end else if (idx == 9) begin
      default_word = cog_pkg::DEF_FIXED;
    end else if (idx == 10) begin
      default_word = cog_pkg::DEF_OSC;
    end else begin
      default_word = cog_pkg::DEF_LOCK;
    end
  endfunction : default_word

  // link decode
  wire        sclk_rise  = sclk_flt && !sclk_prev;
  wire        le_fall    = !le_flt && le_prev;
  wire [4:0]  wr_addr    = shift[4:0];
  wire [3:0]  wr_idx     = reg_index(wr_addr);
  wire        locked     = regs[11][cog_pkg::LOCK_BIT];
  wire        is_reset   = (wr_addr == cog_pkg::ADDR_GROUP0) && shift[cog_pkg::RESET_BIT];
  wire        wr_allowed = !locked || (wr_addr == cog_pkg::ADDR_LOCK);
  wire        do_reset   = le_fall && is_reset && wr_allowed;
  wire        do_write   = le_fall && !is_reset && wr_allowed;
  wire        fire_sync  = do_write && (wr_addr == cog_pkg::ADDR_FEEDBACK);
  wire        dev_pd     = regs[1][cog_pkg::DEV_PD_BIT];
  wire [5:0]  exempt;
  wire [2:0]  osc_div    = osc_divisor(regs[10][cog_pkg::OSC_DIV_LSB +: 3]);
  wire [3:0]  osc0_fmt   = regs[10][cog_pkg::OSC0_FMT_LSB +: 4];
  logic [5:0] sync_exempt;
  assign exempt = sync_exempt;

  // three-stage resync; a level is taken once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_sync <= 3'h0;
      data_sync <= 3'h0;
      le_sync   <= 3'h0;
      sclk_flt  <= 1'b0;
      data_flt  <= 1'b0;
      le_flt    <= 1'b0;
      sclk_prev <= 1'b0;
      le_prev   <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], link.sclk};
      data_sync <= {data_sync[1:0], link.sdata};
      le_sync   <= {le_sync[1:0], link.latch_enable_pin};
      if (sclk_sync[1] == sclk_sync[2]) sclk_flt <= sclk_sync[2];
      if (data_sync[1] == data_sync[2]) data_flt <= data_sync[2];
      if (le_sync[1] == le_sync[2]) le_flt <= le_sync[2];
      sclk_prev <= sclk_flt;
      le_prev   <= le_flt;
    end
  end

  // bits enter msb first while latch enable is high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift <= 32'h0000_0000;
    end else if (sclk_rise && le_flt) begin
      shift <= {shift[30:0], data_flt};
    end
  end

  // register bank
  generate
    for (genvar i = 0; i < cog_pkg::REGS; i++) begin : g_reg
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          regs[i] <= default_word(i);
        end else if (do_reset) begin
          regs[i] <= default_word(i);
        end else if (do_write && wr_idx == 4'(i)) begin
          regs[i] <= shift;
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_exempt      <= cog_pkg::DEF_SYNC_CTL[cog_pkg::NOSYNC_LSB +: 6];
      reset_flag       <= 1'b0;
      output_six_ready <= 1'b0;
      sync_pulse       <= 1'b0;
    end else begin
      if (do_reset) begin
        sync_exempt <= cog_pkg::DEF_SYNC_CTL[cog_pkg::NOSYNC_LSB +: 6];
      end else if (do_write && wr_addr == cog_pkg::ADDR_SYNC_CTL) begin
        sync_exempt <= shift[cog_pkg::NOSYNC_LSB +: 6];
      end
      if (do_reset) begin
        reset_flag <= 1'b1;
      end else if (do_write) begin
        reset_flag <= 1'b0;
      end
      // a reload returns group 3 to defaults, so output six is unusable again
      if (do_reset) begin
        output_six_ready <= 1'b0;
      end else if (do_write && wr_addr == cog_pkg::ADDR_GROUP3) begin
        output_six_ready <= 1'b1;
      end
      sync_pulse <= fire_sync;
    end
  end

  // group dividers: reference is hclk/2, so n hclk high and n low gives n division
  generate
    for (genvar g = 0; g < cog_pkg::GROUPS; g++) begin : g_grp
      wire [10:0] div    = regs[g][cog_pkg::DIV_LSB +: cog_pkg::DIV_W];
      wire        usable = (div != 11'h000) && (div <= cog_pkg::DIV_MAX);
      wire        active = !regs[g][cog_pkg::GRP_PD_BIT] && !dev_pd && usable;
      wire        resync = fire_sync && !exempt[g];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          grp_cnt[g]        <= 11'h000;
          group_clk[g]      <= 1'b0;
          group_extended[g] <= 1'b0;
        end else begin
          group_extended[g] <= div >= cog_pkg::DIV_EXT_MIN;
          if (!active || resync) begin
            grp_cnt[g]   <= 11'h000;
            group_clk[g] <= 1'b0;
          end else if (grp_cnt[g] >= div - 11'h001) begin
            // at or past the end: a smaller divide written mid-count must not wait for the wrap
            grp_cnt[g]   <= 11'h000;
            group_clk[g] <= !group_clk[g];
          end else begin
            grp_cnt[g] <= grp_cnt[g] + 11'h001;
          end
        end
      end
      for (genvar k = 0; k < 2; k++) begin : g_out
        wire [3:0] fmt = regs[cog_pkg::ADDR_FMT_A + (2 * g + k) / 4][cog_pkg::FMT_LSB + 4 * ((2 * g + k) % 4) +: 4];
        always_ff @(posedge hclk or negedge hresetn) begin
          if (!hresetn) begin
            output_format[4 * (2 * g + k) +: 4] <= 4'h0;
            output_on[2 * g + k]                <= 1'b0;
          end else begin
            output_format[4 * (2 * g + k) +: 4] <= fmt;
            output_on[2 * g + k] <= active && fmt != cog_pkg::FMT_OFF && fmt <= cog_pkg::FMT_CMOS_LAST;
          end
        end
      end
    end
  endgenerate

  // oscillator path
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_clk             <= 1'b0;
      osc_cnt             <= 3'h0;
      osc_div_clk         <= 1'b0;
      osc_buf0_on         <= 1'b0;
      osc_buf1_on         <= 1'b0;
      osc_buffer_first    <= 1'b0;
      osc_buffer_second   <= 1'b0;
      osc_buf1_amplitude  <= 2'h0;
      device_powerdown    <= 1'b0;
      register_write_lock <= 1'b0;
    end else begin
      ref_clk <= !ref_clk;
      if (osc_cnt >= osc_div - 3'h1) begin
        osc_cnt     <= 3'h0;
        osc_div_clk <= !osc_div_clk;
      end else begin
        osc_cnt <= osc_cnt + 3'h1;
      end
      osc_buf0_on <= regs[10][cog_pkg::OSC0_EN_BIT] && osc0_fmt != cog_pkg::FMT_OFF && !dev_pd;
      osc_buf1_on <= regs[10][cog_pkg::OSC1_EN_BIT] && !dev_pd;
      osc_buffer_first  <= osc_buf0_on && (regs[10][cog_pkg::OSC0_SEL_BIT] ? osc_div_clk : ref_clk);
      osc_buffer_second <= osc_buf1_on && (regs[10][cog_pkg::OSC1_SEL_BIT] ? osc_div_clk : ref_clk);
      osc_buf1_amplitude  <= regs[10][cog_pkg::OSC1_AMP_LSB +: 2];
      device_powerdown    <= dev_pd;
      register_write_lock <= locked;
    end
  end
endmodule : cog_dev

// ---- src/cog_pkg.sv ----
/*
  Shared constants for the clock output configuration bank and its serial
  host: word layout, register addresses, field positions, defaults, timing.
  Assumes both ends run on one 25 MHz hclk.
*/
package cog_pkg;
  localparam int unsigned CLK_MHZ       = 25;
  localparam int unsigned LINK_HALF_NS  = 320;
  localparam int unsigned LINK_HALF_CYC = (LINK_HALF_NS * CLK_MHZ) / 1000;
  localparam int unsigned WORD_W        = 32;
  localparam int unsigned ADDR_W        = 5;
  localparam int unsigned GROUPS        = 6;
  localparam int unsigned OUTPUTS       = 12;
  localparam int unsigned REGS          = 12;
  // serial register addresses
  localparam logic [4:0] ADDR_GROUP0   = 5'h00;
  localparam logic [4:0] ADDR_GROUP1   = 5'h01;
  localparam logic [4:0] ADDR_GROUP3   = 5'h03;
  localparam logic [4:0] ADDR_GROUP5   = 5'h05;
  localparam logic [4:0] ADDR_FMT_A    = 5'h06;
  localparam logic [4:0] ADDR_FIXED    = 5'h09;
  localparam logic [4:0] ADDR_OSC      = 5'h0A;
  localparam logic [4:0] ADDR_SYNC_CTL = 5'h0B;
  localparam logic [4:0] ADDR_FEEDBACK = 5'h1E;
  localparam logic [4:0] ADDR_LOCK     = 5'h1F;
  localparam logic [3:0] IDX_SYNC_CTL  = 4'hB;
  // field positions
  localparam int unsigned GRP_PD_BIT    = 31;
  localparam int unsigned RESET_BIT     = 17;
  localparam int unsigned DEV_PD_BIT    = 17;
  localparam int unsigned DIV_LSB       = 5;
  localparam int unsigned DIV_W         = 11;
  localparam int unsigned FMT_LSB       = 16;
  localparam int unsigned FMT_W         = 4;
  localparam int unsigned OSC1_AMP_LSB  = 30;
  localparam int unsigned OSC0_FMT_LSB  = 24;
  localparam int unsigned OSC1_EN_BIT   = 23;
  localparam int unsigned OSC0_EN_BIT   = 22;
  localparam int unsigned OSC1_SEL_BIT  = 21;
  localparam int unsigned OSC0_SEL_BIT  = 20;
  localparam int unsigned OSC_DIV_LSB   = 16;
  localparam int unsigned NOSYNC_LSB    = 20;
  localparam int unsigned LOCK_BIT      = 5;
  localparam logic [10:0] DIV_EXT_MIN   = 11'h01A;
  localparam logic [10:0] DIV_MAX       = 11'h415;
  localparam logic [3:0]  FMT_OFF       = 4'h0;
  localparam logic [3:0]  FMT_CMOS_LAST = 4'hE;
  localparam logic [2:0]  OSC_DIV_MAX   = 3'h0;
  localparam logic [2:0]  OSC_DIV_TWO   = 3'h1;
  // power-on contents
  localparam logic [31:0] DEF_GROUP     = 32'h0000_0020;
  localparam logic [31:0] DEF_FMT       = 32'h0000_0000;
  localparam logic [31:0] DEF_FIXED     = 32'h0000_0000;
  localparam logic [31:0] DEF_OSC       = 32'h0040_0000;
  localparam logic [31:0] DEF_SYNC_CTL  = 32'h0180_0000;
  localparam logic [31:0] DEF_LOCK      = 32'h0000_0000;
  // host register map on AHB-Lite
  localparam logic [7:0] HOST_CMD_OFS    = 8'h00;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h04;
  localparam int unsigned ST_BUSY       = 0;
  localparam int unsigned ST_REDO_R0    = 1;
  localparam int unsigned ST_R3_DONE    = 2;
  localparam int unsigned ST_R9_DONE    = 3;
  localparam int unsigned ST_REFUSED    = 4;
endpackage : cog_pkg

// ---- src/cog_link_if.sv ----
/*
  Three-wire serial configuration link between host and device.
  Assumes both ends sit on hclk; the device resynchronises every wire.
*/
`timescale 1ns/1ns
interface cog_link_if;
  logic sclk;
  logic sdata;
  logic latch_enable_pin;
  modport host (output sclk, output sdata, output latch_enable_pin);
  modport dev  (input sclk, input sdata, input latch_enable_pin);
endinterface : cog_link_if

// ---- src/cog_host.sv ----
/*
  Host end: AHB-Lite slave taking configuration words from software and
  sending each one written while idle as one framed 32-bit word on the serial link; a word written while busy is refused.
  Assumes a single AHB master and single-word transfers.
*/
`timescale 1ns/1ns
module cog_host (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // serial link
  cog_link_if.host         link
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LOW   = 4'b0010,
    ST_HIGH  = 4'b0100,
    ST_CLOSE = 4'b1000
  } cog_state_type;

  cog_state_type state;
  logic [31:0]   word;
  logic [4:0]    bit_left;
  logic [7:0]    half_cnt;
  logic          dp_write;
  logic [7:0]    dp_addr;
  logic [4:0]    status;

  wire       addr_phase = hsel && hready && htrans[1];
  wire       busy       = state != ST_IDLE;
  wire       cmd_wr     = dp_write && dp_addr == cog_pkg::HOST_CMD_OFS;
  wire       accept     = cmd_wr && !busy;
  wire       half_done  = half_cnt == 8'(cog_pkg::LINK_HALF_CYC - 1);
  wire [4:0] cmd_addr   = hwdata[4:0];
  wire [31:0] rd_word   = (haddr[7:0] == cog_pkg::HOST_CMD_OFS) ? word :
                          (haddr[7:0] == cog_pkg::HOST_STATUS_OFS) ? {27'h0, status[4:1], busy} : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write  <= 1'b0;
      dp_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_write <= addr_phase && hwrite;
      if (addr_phase) begin
        dp_addr <= haddr[7:0];
        hrdata  <= hwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // status flags; a new cause wins over the software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= 5'h00;
    end else begin
      if (accept && cmd_addr == cog_pkg::ADDR_GROUP0) begin
        status[cog_pkg::ST_REDO_R0] <= hwdata[cog_pkg::RESET_BIT];
      end
      if (accept && cmd_addr == cog_pkg::ADDR_GROUP3) begin
        status[cog_pkg::ST_R3_DONE] <= 1'b1;
      end else if (accept && cmd_addr == cog_pkg::ADDR_GROUP0 && hwdata[cog_pkg::RESET_BIT]) begin
        status[cog_pkg::ST_R3_DONE] <= 1'b0;
      end
      if (accept && cmd_addr == cog_pkg::ADDR_FIXED) begin
        status[cog_pkg::ST_R9_DONE] <= 1'b1;
      end
      if (cmd_wr && busy) begin
        status[cog_pkg::ST_REFUSED] <= 1'b1;
      end else if (dp_write && dp_addr == cog_pkg::HOST_STATUS_OFS && hwdata[cog_pkg::ST_REFUSED]) begin
        status[cog_pkg::ST_REFUSED] <= 1'b0;
      end
    end
  end

  // serialiser: latch enable high, 32 clocks msb first, falling latch enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state                 <= ST_IDLE;
      word                  <= 32'h0000_0000;
      bit_left              <= 5'h00;
      half_cnt              <= 8'h00;
      link.sclk             <= 1'b0;
      link.sdata            <= 1'b0;
      link.latch_enable_pin <= 1'b0;
    end else begin
      half_cnt <= (state == ST_IDLE || half_done) ? 8'h00 : half_cnt + 8'h01;
      case (state)
        ST_IDLE: begin
          if (accept) begin
            word                  <= hwdata;
            bit_left              <= 5'h1F;
            link.sdata            <= hwdata[31];
            link.latch_enable_pin <= 1'b1;
            state                 <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (half_done) begin
            link.sclk <= 1'b1;
            state     <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (half_done) begin
            link.sclk <= 1'b0;
            if (bit_left == 5'h00) begin
              state <= ST_CLOSE;
            end else begin
              bit_left   <= bit_left - 5'h01;
              link.sdata <= word[bit_left - 5'h01];
              state      <= ST_LOW;
            end
          end
        end
        ST_CLOSE: begin
          // the falling latch enable is what commits the word in the device;
          // busy covers one more half period so the low level outlasts the resync
          if (half_done && link.latch_enable_pin) begin
            link.latch_enable_pin <= 1'b0;
          end else if (half_done) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : cog_host

// ---- bench/cog_sva.sv ----
/*
  Checker for the serial link wires: idle level, clock phase lengths,
  data timing and framing of each 32-bit word.
  Assumes both ends run on hclk with hresetn active low.
*/
`timescale 1ns/1ns
module cog_sva (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // serial link
  input wire logic sclk,
  input wire logic sdata,
  input wire logic latch_enable_pin
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire        le = latch_enable_pin;
  logic       sclk_q;
  logic [5:0] rises;
  // counts clock rises inside the current frame only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_q <= 1'b0;
      rises  <= 6'h00;
    end else begin
      sclk_q <= sclk;
      rises  <= le ? rises + {5'h00, sclk & ~sclk_q} : 6'h00;
    end
  end
  sequence s_low8; !sclk [*8]; endsequence
  sequence s_high8; sclk [*8]; endsequence
  property p_idle_low; !le |-> !sclk; endproperty
  a_idle_low: assert property (p_idle_low) else $error("sclk high outside frame");
  property p_frame_len; $fell(le) |-> rises == 6'd32; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not 32 bits");
  property p_high_len; $rose(sclk) |-> s_high8 ##1 !sclk; endproperty
  a_high_len: assert property (p_high_len) else $error("sclk high phase length");
  property p_low_len; $fell(sclk) && le |-> s_low8; endproperty
  a_low_len: assert property (p_low_len) else $error("sclk low phase too short");
  property p_start; $rose(le) |-> !sclk [*3] ##[1:8] $rose(sclk); endproperty
  a_start: assert property (p_start) else $error("frame start timing");
  property p_stable; sclk |=> !sclk || $stable(sdata); endproperty
  a_stable: assert property (p_stable) else $error("sdata moved while sclk high");
  property p_change_low; le && $changed(sdata) |-> !sclk; endproperty
  a_change_low: assert property (p_change_low) else $error("sdata changed with sclk high");
  property p_le_hold; $fell(le) |-> !le [*3]; endproperty
  a_le_hold: assert property (p_le_hold) else $error("latch low too short");
endmodule : cog_sva

// ---- bench/cog_test.sv ----
/*
  Testbench: host and device joined by the link; software side driven
  over AHB-Lite, device outputs judged against expected register effects.
  Assumes a single 25 MHz clock and the package constants.
*/
`timescale 1ns/1ns
module cog_test;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = 2'b00;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] rd;
  wire         hreadyout, hresp;
  wire  [31:0] hrdata;
  wire  [5:0]  group_clk, group_extended;
  wire  [11:0] output_on;
  wire  [47:0] output_format;
  wire  [1:0]  osc_buf1_amplitude;
  wire         osc_buffer_first, osc_buffer_second, osc_buf0_on, osc_buf1_on;
  wire         device_powerdown, reset_flag, register_write_lock, output_six_ready, sync_pulse;
  wire  [7:0]  clks = {osc_buffer_second, osc_buffer_first, group_clk};
  int          num_errors = 0;
  int          checks = 0;
  int          syncs = 0;
  logic [5:0]  gclk_q, at_sync, before_sync;
  always #20 hclk = ~hclk;
  // group clocks just before and just after each sync, for resync and exemption checks
  always @(posedge hclk) begin
    gclk_q <= group_clk;
    if (sync_pulse === 1'b1) begin
      syncs++;
      at_sync     = group_clk;
      before_sync = gclk_q;
    end
  end
  cog_link_if cog_link_if_inst ();
  cog_host cog_host_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .link(cog_link_if_inst));
  cog_dev cog_dev_inst (.hclk, .hresetn, .link(cog_link_if_inst), .group_clk, .group_extended,
    .output_on, .output_format, .osc_buffer_first, .osc_buffer_second, .osc_buf0_on, .osc_buf1_on,
    .osc_buf1_amplitude, .device_powerdown, .reset_flag, .register_write_lock, .output_six_ready,
    .sync_pulse);
  cog_sva cog_sva_inst (.hclk, .hresetn, .sclk(cog_link_if_inst.sclk), .sdata(cog_link_if_inst.sdata),
    .latch_enable_pin(cog_link_if_inst.latch_enable_pin));

  task automatic conclude;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic check(input logic [63:0] e, input logic [63:0] a);
    checks++;
    if (a !== e) begin
      num_errors++;
      $display("Error at %0t: expected %h got %h", $time, e, a);
    end
  endtask : check

  task automatic guard(input int n);
    if (n <= 0) begin
      num_errors++;
      $display("Error at %0t: wait expected %h got %h", $time, 1'b1, 1'b0);
      conclude();
    end
  endtask : guard

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 200;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1 && --n > 0);
    guard(n);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && --n > 0);
    guard(n);
    rd = hrdata;
  endtask : ahb

  // the serial frame outlasts many polls, so poll until busy drops
  task automatic idle;
    int n;
    n = 1000;
    do ahb(1'b0, cog_pkg::HOST_STATUS_OFS, 32'h0); while (rd[cog_pkg::ST_BUSY] !== 1'b0 && --n > 0);
    guard(n);
    repeat (8) @(posedge hclk);
  endtask : idle

  task automatic send(input logic [31:0] w);
    ahb(1'b1, cog_pkg::HOST_CMD_OFS, w);
    idle();
  endtask : send

  task automatic period(input int i, input int hi);
    int n, h, l;
    n = 0;
    h = 0;
    l = 0;
    while (clks[i] !== 1'b0 && n < 99) begin n++; @(posedge hclk); end
    while (clks[i] !== 1'b1 && n < 99) begin n++; @(posedge hclk); end
    while (clks[i] === 1'b1 && h < 99) begin h++; @(posedge hclk); end
    while (clks[i] === 1'b0 && l < 99) begin l++; @(posedge hclk); end
    check(hi, h);
    check(hi, l);
  endtask : period

  task automatic quiet(input logic [7:0] m);
    int h;
    h = 0;
    repeat (40) begin
      @(posedge hclk);
      if ((clks & m) !== 8'h00) h++;
    end
    check(0, h);
  endtask : quiet

  task automatic t_reset;
    check(48'h0, output_format);
    check(2'b10, {hreadyout, hresp});
    check(4'h0, {group_extended[0], register_write_lock, output_six_ready, device_powerdown});
    ahb(1'b0, 8'h08, 32'h0);
    check(32'h0, rd);
    $display("reset test done");
  endtask : t_reset

  task automatic t_format;
    for (int c = 0; c < 16; c++) begin
      send({c[3:0], 8'h00, c[3:0], 16'h0006});
      check({c[3:0], 8'h00, c[3:0]}, output_format[15:0]);
      check(c > 0 && c < 15, output_on[0]);
    end
    send(32'hCBA9_0008);
    check(16'hCBA9, output_format[47:32]);
    $display("format test done");
  endtask : t_format

  task automatic t_groups;
    send(32'h1001_0006);
    send({16'h0, cog_pkg::DIV_EXT_MIN, 5'h00});
    send({16'h0, 11'd25, 5'h01});
    check(2'b01, group_extended[1:0]);
    send({16'h0, cog_pkg::DIV_MAX, 5'h05});
    check(1'b1, group_extended[5]);
    send({16'h0, 11'd3, 5'h00});
    period(0, 3);
    send({1'b1, 15'h0, 11'd3, 5'h00});
    check(3'b100, output_on[3:1] & 3'b100 | {1'b0, output_on[1:0]});
    quiet(8'h01);
    period(1, 25);
    $display("group test done");
  endtask : t_groups

  task automatic t_devpd;
    send({14'h0, 1'b1, 1'b0, 11'd25, 5'h01});
    check(1'b1, device_powerdown);
    quiet(8'hFF);
    send({16'h0, 11'd25, 5'h01});
    check(1'b0, device_powerdown);
    period(1, 25);
    $display("powerdown test done");
  endtask : t_devpd

  task automatic t_reset_bit;
    send({1'b1, 13'h0, 1'b1, 1'b0, cog_pkg::DIV_EXT_MIN, 5'h00});
    check(1'b1, reset_flag);
    check(54'h0, {output_format, group_extended});
    period(0, 1);
    ahb(1'b0, cog_pkg::HOST_STATUS_OFS, 32'h0);
    check(1'b1, rd[cog_pkg::ST_REDO_R0]);
    send({27'h0, cog_pkg::ADDR_GROUP3});
    check(2'b01, {reset_flag, output_six_ready});
    send({16'h0, cog_pkg::DIV_EXT_MIN, 5'h00});
    check(1'b1, group_extended[0]);
    ahb(1'b0, cog_pkg::HOST_STATUS_OFS, 32'h0);
    check(2'b10, rd[2:1]);
    $display("reset bit test done");
  endtask : t_reset_bit

  task automatic t_osc;
    for (int k = 0; k < 15; k++) begin
      send({k[1:0], 2'b00, k[3:0], 2'b11, 6'h00, 11'h0, 5'h0A});
      check(k[1:0], osc_buf1_amplitude);
      check({k != 0, 1'b1}, {osc_buf0_on, osc_buf1_on});
    end
    send(32'h81C3_000A);
    period(6, 1);
    send(32'h81D3_000A);
    period(6, 3);
    send(32'h81F0_000A);
    period(7, 8);
    send(32'hC100_000A);
    check(4'h3, {osc_buf0_on, osc_buf1_on, osc_buf1_amplitude});
    $display("oscillator test done");
  endtask : t_osc

  task automatic t_lock;
    send(32'h0000_003F);
    check(1'b1, register_write_lock);
    send(32'h0005_0006);
    send({14'h0, 1'b1, 17'h0});
    check(5'h00, {reset_flag, output_format[3:0]});
    send(32'h0000_001F);
    send(32'h0005_0006);
    check(5'h05, {register_write_lock, output_format[3:0]});
    $display("lock test done");
  endtask : t_lock

  task automatic t_sync_refuse;
    int s;
    send(32'h0000_0020);
    send({6'h00, 6'h02, 15'h0000, cog_pkg::ADDR_SYNC_CTL});
    s = syncs;
    send({27'h0, cog_pkg::ADDR_FEEDBACK});
    check(s + 1, syncs);
    check(1'b0, at_sync[0]);
    check(!before_sync[1], at_sync[1]);
    ahb(1'b1, cog_pkg::HOST_CMD_OFS, {27'h0, cog_pkg::ADDR_FIXED});
    ahb(1'b1, cog_pkg::HOST_CMD_OFS, 32'h0000_0006);
    ahb(1'b0, cog_pkg::HOST_STATUS_OFS, 32'h0);
    check(1'b1, rd[cog_pkg::ST_REFUSED]);
    idle();
    ahb(1'b1, cog_pkg::HOST_STATUS_OFS, 32'h10);
    ahb(1'b0, cog_pkg::HOST_STATUS_OFS, 32'h0);
    check(2'b01, {rd[cog_pkg::ST_REFUSED], rd[cog_pkg::ST_R9_DONE]});
    $display("sync and refusal test done");
  endtask : t_sync_refuse

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_format();
    t_groups();
    t_devpd();
    t_reset_bit();
    t_osc();
    t_lock();
    t_sync_refuse();
    conclude();
  end
endmodule : cog_test
